// file: logic/dac_load_reset_readback.sv
`timescale 1ns/100ps
`include "dlrb_consts.svh"

// Notes on behaviour
// - Software reset zeroes the output and restores input, output and control registers.
// - Writing 1 into control bit 15 starts the software reset.
// - The reset bit clears itself when the software reset finishes.
// - A matching read address is acknowledged by pulling the data line low.
// - A read returns two bytes holding the input register.
// - An active load strobe copies the input register into the output register.
// - Strobe low during an input write also updates the output register.
// - A strobe falling edge outside transfers moves input to output register.
// - A strobe pulse during a bus transfer is ignored.
// - Reset pin low zeroes the output and restores all registers.
// - After reset the output stays at zero until reprogrammed.
// - While the reset pin is low, bus commands are ignored.
// - Internal source start-up waits until the reset pin is released.
// - Control layout: reset 15, power-down 14 and 13, source off 12, gain 11.
// - Command 2 copies input to output register, ignoring its data.
// - Direct writes to the output register also refresh the input register.
// - The internal source control bit defaults to enabled after any reset.
module dac_load_reset_readback (
   // System clock and synchronous reset.
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // Two-wire bus; the data line is open drain.
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   // Device pins.
   input  wire logic        addr_sel_i,
   input  wire logic        load_strobe_n_i,
   input  wire logic        reset_pin_n_i,
   // Converter controls.
   output logic [15:0]      analog_output_code_o,
   output logic [15:0]      input_code_o,
   output logic             powerdown_select_hi_o,
   output logic             powerdown_select_lo_o,
   output logic             gain_o,
   output logic             ref_enable_o,
   output logic             soft_reset_busy_o
);

   // Link domain state.
   logic                    link_clr;
   logic                    start_tog;
   logic                    start_ack;
   logic [3:0]              bit_cnt;
   logic [1:0]              byte_cnt;
   logic [7:0]              rx;
   logic [7:0]              cmd_byte;
   logic [7:0]              hi_byte;
   logic [15:0]             tx;
   logic                    tx_act;
   logic                    drive;
   logic                    mack;
   logic                    wtog;
   logic                    a0_m;
   logic                    a0_s;
   dlrb_pkg::wcmd_t         pend;
   dlrb_pkg::link_state_t   lstate;

   // System domain state.
   logic [4:0]              sync_m;
   logic [4:0]              sync_s;
   logic [2:0]              prev;
   logic                    busy;
   logic                    ref_ready;
   logic                    ref_en;
   logic [15:0]             inp;
   logic [15:0]             dac;
   logic [15:0]             rb;
   logic [`SWCNT_W-1:0]     swcnt;
   dlrb_pkg::ctrl_t         ctrl;
   dlrb_pkg::core_state_t   state;

   // Link domain decode.
   wire                     link_start = start_tog ^ start_ack;
   wire                     addr_hit   = (rx[7:1] == {`ADDR_FIXED, a0_s, 1'h0});
   wire [1:0]               next_byte  = (byte_cnt == `BYTE_SAT) ? `BYTE_SAT
                                                                 : byte_cnt + 2'h1;
   wire                     tx_go      = (lstate == dlrb_pkg::L_READ) && !mack &&
                                         (byte_cnt != `BYTE_LO);

   // A start is an sda fall while scl is high; it toggles a marker for the link.
   always_ff @(negedge sda_i or posedge link_clr)
   begin
      if (link_clr)
         start_tog <= 1'h0;
      else if (scl_i)
         start_tog <= ~start_tog;
   end

   // Rising scl samples data bits, the master acknowledge and the address pin.
   always_ff @(posedge scl_i or posedge link_clr)
   begin
      if (link_clr)
      begin
         rx   <= 8'h00;
         mack <= 1'h1;
         a0_m <= 1'h0;
         a0_s <= 1'h0;
      end
      else
      begin
         a0_m <= addr_sel_i;
         a0_s <= a0_m;
         if (bit_cnt == `BIT_ACK)
            mack <= sda_i;
         else
            rx <= {rx[6:0], sda_i};
      end
   end

   // Falling scl advances the bit slot and changes what the device drives.
   always_ff @(negedge scl_i or posedge link_clr)
   begin
      if (link_clr)
      begin
         start_ack <= 1'h0;
         bit_cnt   <= `BIT_FIRST;
         byte_cnt  <= `BYTE_FIRST;
         lstate    <= dlrb_pkg::L_SKIP;
         drive     <= 1'h0;
         tx        <= `CODE_ZERO;
         tx_act    <= 1'h0;
         cmd_byte  <= 8'h00;
         hi_byte   <= 8'h00;
         pend      <= '0;
         wtog      <= 1'h0;
      end
      else
      begin
         start_ack <= start_tog;
         if (link_start)
         begin
            bit_cnt  <= `BIT_FIRST;
            byte_cnt <= `BYTE_FIRST;
            lstate   <= dlrb_pkg::L_ADDR;
            drive    <= 1'h0;
            tx_act   <= 1'h0;
         end
         else if (bit_cnt == `BIT_LAST)
         begin
            bit_cnt <= `BIT_ACK;
            tx_act  <= 1'h0;
            case (lstate)
               dlrb_pkg::L_ADDR:
               begin
                  drive  <= addr_hit;
                  tx     <= rb;
                  lstate <= !addr_hit ? dlrb_pkg::L_SKIP
                          : rx[0] ? dlrb_pkg::L_READ : dlrb_pkg::L_WRITE;
               end
               dlrb_pkg::L_WRITE:
               begin
                  drive    <= 1'h1;
                  byte_cnt <= next_byte;
                  if (byte_cnt == `BYTE_FIRST)
                     cmd_byte <= rx;
                  if (byte_cnt == `BYTE_HI)
                     hi_byte <= rx;
                  // The word is complete on the fall before its acknowledge.
                  if (byte_cnt == `BYTE_LO)
                  begin
                     pend <= {cmd_byte[7:4], hi_byte, rx};
                     wtog <= ~wtog;
                  end
               end
               dlrb_pkg::L_READ:
               begin
                  drive    <= 1'h0;
                  byte_cnt <= next_byte;
               end
               default:
                  drive <= 1'h0;
            endcase
         end
         else if (bit_cnt == `BIT_ACK)
         begin
            // A read byte starts only after our own or the master's acknowledge.
            bit_cnt <= `BIT_FIRST;
            tx_act  <= tx_go;
            drive   <= tx_go & ~tx[15];
            if (tx_go)
               tx <= {tx[14:0], 1'h0};
         end
         else
         begin
            bit_cnt <= bit_cnt + 4'h1;
            drive   <= tx_act & ~tx[15];
            if (tx_act)
               tx <= {tx[14:0], 1'h0};
         end
      end
   end

   // System domain decode.
   wire                     scl_s    = sync_s[4];
   wire                     sda_s    = sync_s[3];
   wire                     rst_s    = sync_s[2];
   wire                     ld_s     = sync_s[1];
   wire                     wt_s     = sync_s[0];
   wire                     bus_start = scl_s & prev[2] & ~sda_s;
   wire                     bus_stop  = scl_s & ~prev[2] & sda_s;
   wire                     run      = (state == dlrb_pkg::C_RUN);
   wire                     w_ev     = (wt_s ^ prev[0]) & run;
   wire                     ld_fall  = prev[1] & ~ld_s;
   wire                     wr_in    = w_ev && (pend.cmd == `CMD_WR_INPUT);
   wire                     wr_load  = w_ev && (pend.cmd == `CMD_LOAD);
   wire                     wr_both  = w_ev && (pend.cmd == `CMD_WR_BOTH);
   wire                     wr_ctrl  = w_ev && (pend.cmd == `CMD_WR_CTRL);
   wire                     hw_load  = ld_fall & ~busy & run;
   wire                     sw_done  = (state == dlrb_pkg::C_SWRST) &&
                                       (swcnt == `SWCNT_W'(`SWRST_CYCLES - 1));
   wire dlrb_pkg::ctrl_t    wr_fields = dlrb_pkg::ctrl_t'(pend.data[`CTRL_MSB:`CTRL_LSB]);

   // Next register contents.
   wire [15:0]              next_inp  = sw_done ? `CODE_ZERO
                                      : (wr_in | wr_both) ? pend.data : inp;
   wire [15:0]              next_dac  = sw_done ? `CODE_ZERO
                                      : (wr_both | (wr_in & ~ld_s)) ? pend.data
                                      : (wr_load | hw_load) ? inp : dac;
   wire dlrb_pkg::ctrl_t    next_ctrl = sw_done ? dlrb_pkg::ctrl_t'(`CTRL_DEFAULT)
                                      : wr_ctrl ? wr_fields : ctrl;
   wire dlrb_pkg::core_state_t next_state =
                                        (wr_ctrl & wr_fields.reset) ? dlrb_pkg::C_SWRST
                                      : sw_done ? dlrb_pkg::C_RUN : state;
   wire [`SWCNT_W-1:0]      next_swcnt = (state == dlrb_pkg::C_SWRST) ? swcnt + 4'h1
                                       : {`SWCNT_W{1'h0}};

   // Pins pass two flip-flops before use; the first stage feeds only the second.
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         sync_m <= `SYNC_INIT;
         sync_s <= `SYNC_INIT;
         prev   <= 3'h6;
      end
      else
      begin
         sync_m <= {scl_i, sda_i, reset_pin_n_i, load_strobe_n_i, wtog};
         sync_s <= sync_m;
         prev   <= {sda_s, ld_s, wt_s};
      end
   end

   // Bus activity, link reset and the source start-up gate.
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         link_clr  <= 1'h1;
         busy      <= 1'h0;
         ref_ready <= 1'h0;
      end
      else
      begin
         link_clr  <= ~rst_s;
         busy      <= rst_s & (bus_start | (busy & ~bus_stop));
         ref_ready <= ref_ready | rst_s;
      end
   end

   // Register file and software reset sequencer.
   always_ff @(posedge clk_i)
   begin
      if (srst_i || !rst_s)
      begin
         inp   <= `CODE_ZERO;
         dac   <= `CODE_ZERO;
         ctrl  <= dlrb_pkg::ctrl_t'(`CTRL_DEFAULT);
         state <= dlrb_pkg::C_RUN;
         swcnt <= {`SWCNT_W{1'h0}};
         rb    <= `CODE_ZERO;
      end
      else
      begin
         inp   <= next_inp;
         dac   <= next_dac;
         ctrl  <= next_ctrl;
         state <= next_state;
         swcnt <= next_swcnt;
         if (!busy)
            rb <= inp;
      end
   end

   // Output flops for the source enable.
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
         ref_en <= 1'h0;
      else
         ref_en <= ref_ready & ~ctrl.ref_off;
   end

   // Port drive.
   assign sda_o                 = 1'h0;
   assign sda_oe_o              = drive;
   assign analog_output_code_o  = dac;
   assign input_code_o          = inp;
   assign powerdown_select_hi_o = ctrl.powerdown_select_hi;
   assign powerdown_select_lo_o = ctrl.powerdown_select_lo;
   assign gain_o                = ctrl.gain;
   assign ref_enable_o          = ref_en;
   assign soft_reset_busy_o     = ctrl.reset;

endmodule

// file: logic/dlrb_consts.svh
`ifndef DLRB_CONSTS_SVH
`define DLRB_CONSTS_SVH
// System clock period and software reset duration.
`define CLK_PERIOD_NS 20
`define SWRST_TIME_NS 100
`define SWRST_CYCLES ((`SWRST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SWCNT_W 4
// Fixed upper five bits of the bus address.
`define ADDR_FIXED 5'h13
// Command codes, taken from the upper nibble of the command byte.
`define CMD_WR_INPUT 4'h1
`define CMD_LOAD 4'h2
`define CMD_WR_BOTH 4'h3
`define CMD_WR_CTRL 4'h4
// Reset contents of the code and control registers.
`define CODE_ZERO 16'h0000
`define CTRL_DEFAULT 5'h00
// Control field position inside the data word.
`define CTRL_MSB 15
`define CTRL_LSB 11
// Bit phases within a nine-clock byte slot.
`define BIT_FIRST 4'h0
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
// Byte slots within one transfer.
`define BYTE_FIRST 2'h0
`define BYTE_HI 2'h1
`define BYTE_LO 2'h2
`define BYTE_SAT 2'h3
// Synchroniser reset pattern: scl, sda, reset pin, load strobe, write toggle.
// The reset pin reads as held until it is really sampled, so a pin kept low
// through a system reset still defers the source start-up.
`define SYNC_INIT 5'h1A
`endif

// file: logic/dlrb_pkg.sv
package dlrb_pkg;
   // Control register fields, most significant first.
   typedef struct packed {
      logic reset;
      logic powerdown_select_hi;
      logic powerdown_select_lo;
      logic ref_off;
      logic gain;
   } ctrl_t;
   // A completed write: command nibble and two data bytes.
   typedef struct packed {
      logic [3:0]  cmd;
      logic [15:0] data;
   } wcmd_t;
   // Core sequencer states.
   typedef enum logic [1:0] {
      C_RUN   = 2'h1,
      C_SWRST = 2'h2
   } core_state_t;
   // Link byte-level states.
   typedef enum logic [3:0] {
      L_ADDR  = 4'h1,
      L_WRITE = 4'h2,
      L_READ  = 4'h4,
      L_SKIP  = 4'h8
   } link_state_t;
endpackage

// file: sim/dac_load_reset_readback_test.sv
`timescale 1ns/100ps
module dac_load_reset_readback_test;
   logic        clk_i, srst_i, ld_n, rst_n, scl, sda_low, sda_val, sda_oe, ok, seen_busy;
   logic        pd_hi, pd_lo, gain, ref_en, busy;
   logic [15:0] out_code, in_code, v;
   logic [7:0]  r;
   wire         sda_w;
   int          n_mismatch, n_checks;
   // Open-drain data line with a pull-up.
   assign sda_w = ~(sda_low | (sda_oe & ~sda_val));
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) if (busy === 1'h1) seen_busy <= 1'h1;
   tw_master u_tw_master (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));
   dac_load_reset_readback u_dac_load_reset_readback (.clk_i(clk_i), .srst_i(srst_i),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_val), .sda_oe_o(sda_oe), .addr_sel_i(1'h0),
      .load_strobe_n_i(ld_n), .reset_pin_n_i(rst_n), .analog_output_code_o(out_code),
      .input_code_o(in_code), .powerdown_select_hi_o(pd_hi), .powerdown_select_lo_o(pd_lo),
      .gain_o(gain), .ref_enable_o(ref_en), .soft_reset_busy_o(busy));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // Full write frame; ok is high only if every byte was acknowledged.
   task automatic wr(input logic [3:0] cmd, input logic [15:0] d, output logic ok);
      logic [3:0] a;
      u_tw_master.start_cond();
      u_tw_master.byte_slot(8'h98, 1'h1, r, a[0]);
      u_tw_master.byte_slot({cmd, 4'h0}, 1'h1, r, a[1]);
      u_tw_master.byte_slot(d[15:8], 1'h1, r, a[2]);
      u_tw_master.byte_slot(d[7:0], 1'h1, r, a[3]);
      u_tw_master.stop_cond();
      ok = (a === 4'h0);
      repeat (8) @(posedge clk_i);
   endtask
   // Read frame: acknowledge the first byte, refuse the second, then stop.
   task automatic rd(output logic [15:0] d, output logic ok);
      logic a, b;
      u_tw_master.start_cond();
      u_tw_master.byte_slot(8'h99, 1'h1, r, a);
      u_tw_master.byte_slot(8'hFF, 1'h0, d[15:8], b);
      u_tw_master.byte_slot(8'hFF, 1'h1, d[7:0], b);
      u_tw_master.stop_cond();
      ok = (a === 1'h0);
   endtask
   // Strobe kept high through the frame, lowered only after the stop.
   task automatic t_async();
      wr(4'h1, 16'h1234, ok);
      chk("ack", 16'h0001, {15'h0000, ok});
      chk("output", 16'h0000, out_code);
      @(posedge clk_i) ld_n <= 1'h0;
      repeat (8) @(posedge clk_i);
      chk("output", 16'h1234, out_code);
      @(posedge clk_i) ld_n <= 1'h1;
   endtask
   // Strobe low during the write moves the word straight through.
   task automatic t_sync();
      @(posedge clk_i) ld_n <= 1'h0;
      repeat (4) @(posedge clk_i);
      wr(4'h1, 16'h5678, ok);
      chk("output", 16'h5678, out_code);
      chk("input", 16'h5678, in_code);
      @(posedge clk_i) ld_n <= 1'h1;
   endtask
   // A strobe pulse inside a frame does nothing; read back and software load follow.
   task automatic t_ignored();
      fork
         wr(4'h1, 16'hABCD, ok);
         begin
            repeat (30) @(posedge clk_i) ld_n <= 1'h0;
            repeat (5) @(posedge clk_i) ld_n <= 1'h1;
         end
      join
      chk("output", 16'h5678, out_code);
      rd(v, ok);
      chk("read ack", 16'h0001, {15'h0000, ok});
      chk("read data", 16'hABCD, v);
      wr(4'h2, 16'hFFFF, ok);
      chk("output", 16'hABCD, out_code);
      chk("input", 16'hABCD, in_code);
   endtask
   // Foreign address is refused; write both registers.
   task automatic t_both();
      u_tw_master.start_cond();
      u_tw_master.byte_slot(8'h9C, 1'h1, r, ok);
      u_tw_master.stop_cond();
      chk("foreign ack", 16'h0001, {15'h0000, ok});
      wr(4'h3, 16'h2468, ok);
      chk("output", 16'h2468, out_code);
      chk("input", 16'h2468, in_code);
   endtask
   // Control fields, then a software reset.
   task automatic t_ctrl();
      wr(4'h4, 16'h7800, ok);
      chk("ctrl", 16'h000D, {12'h000, pd_hi, pd_lo, ref_en, gain});
      seen_busy = 1'h0;
      wr(4'h4, 16'h8000, ok);
      chk("busy seen", 16'h0001, {15'h0000, seen_busy});
      chk("busy", 16'h0000, {15'h0000, busy});
      chk("output", 16'h0000, out_code);
      chk("input", 16'h0000, in_code);
      chk("ctrl", 16'h0002, {12'h000, pd_hi, pd_lo, ref_en, gain});
   endtask
   // Reset pin held low across a whole frame, well beyond its minimum.
   task automatic t_pin();
      wr(4'h3, 16'h4321, ok);
      wr(4'h4, 16'h0800, ok);
      @(posedge clk_i) rst_n <= 1'h0;
      wr(4'h3, 16'h9999, ok);
      chk("ack", 16'h0000, {15'h0000, ok});
      chk("output", 16'h0000, out_code);
      chk("ctrl", 16'h0000, {15'h0000, gain});
      @(posedge clk_i) rst_n <= 1'h1;
      repeat (20) @(posedge clk_i);
      chk("output", 16'h0000, out_code);
      chk("ref", 16'h0001, {15'h0000, ref_en});
   endtask
   // Reset pin held low through a system reset: the source waits for its release.
   task automatic t_pwrup();
      @(posedge clk_i);
      rst_n  <= 1'h0;
      srst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'h0;
      repeat (10) @(posedge clk_i);
      chk("ref held", 16'h0000, {15'h0000, ref_en});
      rst_n <= 1'h1;
      repeat (8) @(posedge clk_i);
      chk("ref", 16'h0001, {15'h0000, ref_en});
      chk("output", 16'h0000, out_code);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      clk_i = 1'h0;
      srst_i = 1'h1;
      ld_n = 1'h1;
      rst_n = 1'h1;
      seen_busy = 1'h0;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'h0;
      repeat (6) @(posedge clk_i);
      t_async();
      t_sync();
      t_ignored();
      t_both();
      t_ctrl();
      t_pin();
      t_pwrup();
      finish_test();
   end
   // Cuts a hang short; the sequence needs well under a tenth of this.
   initial
   begin
      #400000;
      n_mismatch++;
      finish_test();
   end
endmodule

// file: sim/dlrb_monitor.sv
`timescale 1ns/100ps
module dlrb_monitor (
   // Clock and reset.
   input wire logic        clk_i,
   input wire logic        srst_i,
   // Bus and pins.
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        sda_o,
   input wire logic        sda_oe_o,
   input wire logic        addr_sel_i,
   input wire logic        load_strobe_n_i,
   input wire logic        reset_pin_n_i,
   // Converter controls.
   input wire logic [15:0] analog_output_code_o,
   input wire logic [15:0] input_code_o,
   input wire logic        powerdown_select_hi_o,
   input wire logic        powerdown_select_lo_o,
   input wire logic        gain_o,
   input wire logic        ref_enable_o,
   input wire logic        soft_reset_busy_o
);
   // All checks sample on the system clock and rest during reset.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   a_sda_value: assert property (sda_o == 1'h0)
      else $error("data value not low");
   a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data enable moved while clock high");
   a_busy_width: assert property ($rose(soft_reset_busy_o) |->
      soft_reset_busy_o[*5] ##1 !soft_reset_busy_o)
      else $error("soft reset length wrong");
   a_swrst_clear: assert property ($fell(soft_reset_busy_o) |-> ##[0:1]
      (analog_output_code_o == 16'h0000 && input_code_o == 16'h0000 && !gain_o &&
       !powerdown_select_hi_o && !powerdown_select_lo_o))
      else $error("soft reset left state");
   a_busy_hold: assert property (soft_reset_busy_o && $past(soft_reset_busy_o) |->
      $stable(input_code_o))
      else $error("input moved during soft reset");
   a_pin_clear: assert property (!reset_pin_n_i[*5] |->
      (analog_output_code_o == 16'h0000 && input_code_o == 16'h0000 && !gain_o &&
       !soft_reset_busy_o))
      else $error("reset pin did not clear");
   a_pin_no_ack: assert property (!reset_pin_n_i[*6] |-> !sda_oe_o)
      else $error("ack while reset pin low");
   a_release_zero: assert property (!reset_pin_n_i[*5] ##1 reset_pin_n_i |->
      (analog_output_code_o == 16'h0000)[*8])
      else $error("output left zero after reset pin");
   a_ref_deferred: assert property ($rose(ref_enable_o) |-> $past(reset_pin_n_i, 2))
      else $error("source started under reset pin");
   a_load_source: assert property ($changed(analog_output_code_o) &&
      analog_output_code_o != 16'h0000 |-> ##[0:1] analog_output_code_o == input_code_o)
      else $error("output not from input register");
endmodule
bind dac_load_reset_readback dlrb_monitor u_dlrb_monitor (.clk_i(clk_i), .srst_i(srst_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_i(addr_sel_i),
   .load_strobe_n_i(load_strobe_n_i), .reset_pin_n_i(reset_pin_n_i),
   .analog_output_code_o(analog_output_code_o), .input_code_o(input_code_o),
   .powerdown_select_hi_o(powerdown_select_hi_o), .powerdown_select_lo_o(powerdown_select_lo_o),
   .gain_o(gain_o), .ref_enable_o(ref_enable_o), .soft_reset_busy_o(soft_reset_busy_o));

// file: sim/tw_master.sv
`timescale 1ns/100ps
module tw_master (
   // Bus lines; the data line is resolved with a pull-up outside.
   output logic             scl_o,
   output logic             sda_low_o,
   input  wire logic        sda_i
);
   // The bus clock stands high and the data line is released between frames.
   initial
   begin
      scl_o = 1'h1;
      sda_low_o = 1'h0;
   end
   // Start: data falls while the clock is high, held long enough to be seen.
   task automatic start_cond();
      sda_low_o = 1'h1;
      #48;
      scl_o = 1'h0;
   endtask
   // One bit: data moves only while the clock is low, read just before the fall.
   task automatic bit_slot(input logic b, output logic r);
      #4;
      sda_low_o = ~b;
      #20;
      scl_o = 1'h1;
      #20;
      r = sda_i;
      #4;
      scl_o = 1'h0;
   endtask
   // Eight bits then the acknowledge slot; a one releases the line.
   task automatic byte_slot(input logic [7:0] b, input logic ak, output logic [7:0] r,
                            output logic ak_seen);
      for (int i = 7; i >= 0; i--)
         bit_slot(b[i], r[i]);
      bit_slot(ak, ak_seen);
   endtask
   // Stop: data rises while the clock is high; it always closes a read.
   task automatic stop_cond();
      #4;
      sda_low_o = 1'h1;
      #20;
      scl_o = 1'h1;
      #48;
      sda_low_o = 1'h0;
      #48;
   endtask
endmodule
